// *** rtl/hpp_pkg.sv ***
package hpp_pkg;

  localparam int unsigned MEM_WORDS = 2048;
  localparam int unsigned MEM_AW = 11;
  localparam int unsigned SYNC_STAGES = 2;
  // internal memory access takes this many cycles after a word completes
  localparam logic [2:0] MEM_BUSY_CYCLES = 3'h2;
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  // field positions in the control register
  localparam int unsigned CTL_ORDER_BIT = 0;
  localparam int unsigned CTL_IRQ_BIT = 3;
  localparam logic [15:0] CTL_WRITE_MASK = 16'h0009;

  typedef enum logic [1:0]
  {
    SEL_CONTROL = 2'b00,
    SEL_DATA_INC = 2'b01,
    SEL_POINTER = 2'b10,
    SEL_DATA_KEEP = 2'b11
  } hpp_sel_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_MEM = 2'b10
  } hpp_state_t;

  // host pins after synchronisation
  typedef struct packed {
    logic addr_strobe_n;
    logic port_select_n;
    logic data_strobe_a;
    logic data_strobe_b;
    logic host_read_write;
    logic second_byte_flag;
    logic register_select_hi;
    logic register_select_lo;
    logic emulation_float_n;
    logic [7:0] host_data_bus;
  } hpp_pins_t;

  // fields captured at the start of an access
  typedef struct packed {
    logic read;
    logic second;
    hpp_sel_t sel;
  } hpp_cmd_t;

  typedef struct packed {
    hpp_pins_t s1;
    hpp_pins_t s2;
    logic as_prev;
    logic act_prev;
    hpp_cmd_t cmd;
    logic cmd_latched;
    hpp_state_t state;
    logic [2:0] busy_cnt;
    logic [15:0] pointer;
    logic [15:0] control;
    logic [15:0] latch;
    logic [7:0] first_byte;
    logic mem_we;
    logic [10:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [7:0] dout;
    logic dout_en;
    logic ready;
    logic ready_en;
    logic irq;
    logic irq_en;
  } hpp_state_s_t;

endpackage

// *** rtl/hpp_host_port.sv ***
`timescale 1ns/1ps
module hpp_host_port
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_addr_strobe_n,
  input wire logic i_port_select_n,
  input wire logic i_data_strobe_a,
  input wire logic i_data_strobe_b,
  input wire logic i_host_read_write,
  input wire logic i_second_byte_flag,
  input wire logic i_register_select_hi,
  input wire logic i_register_select_lo,
  input wire logic i_emulation_float_n,
  input wire logic [7:0] i_host_data_bus,
  input wire logic i_cpu_set_irq,
  output logic [7:0] o_host_data_bus,
  output logic o_host_data_bus_oe,
  output logic o_port_ready_out,
  output logic o_port_ready_out_oe,
  output logic o_host_irq_out,
  output logic o_host_irq_out_oe,
  output logic o_byte_order_bit
);

  hpp_pkg::hpp_state_s_t r_q;
  hpp_pkg::hpp_state_s_t r_d;
  hpp_pkg::hpp_pins_t pins_raw;
  logic [15:0] mem [0:hpp_pkg::MEM_WORDS-1];
  logic [15:0] mem_rdata;

  // combined enable: select low and strobes xor-ed active (the two strobes differ)
  function automatic logic access_on(input hpp_pkg::hpp_pins_t p);
    access_on = !p.port_select_n && !(p.data_strobe_a ~^ p.data_strobe_b);
  endfunction

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic second,
                                            input logic order_bit);
    // first byte is high half when byte order bit clear
    pick_byte = (second ^ order_bit) ? w[7:0] : w[15:8];
  endfunction

  assign pins_raw = '{i_addr_strobe_n, i_port_select_n, i_data_strobe_a, i_data_strobe_b,
                      i_host_read_write, i_second_byte_flag, i_register_select_hi,
                      i_register_select_lo, i_emulation_float_n, i_host_data_bus};

  always_ff @(posedge i_sys_clk)
  begin
    if (r_q.mem_we)
    begin
      mem[r_q.mem_addr] <= r_q.mem_wdata;
    end
    mem_rdata <= mem[r_d.mem_addr];
  end

  always_comb
  begin
    logic act;
    logic order_bit;
    logic [15:0] word;
    logic [15:0] next_ptr;
    hpp_pkg::hpp_cmd_t c;
    act = 1'b0;
    order_bit = 1'b0;
    word = 16'h0000;
    next_ptr = 16'h0000;
    c = '0;
    r_d = r_q;
    r_d.s1 = pins_raw;
    r_d.s2 = r_q.s1;
    r_d.mem_we = 1'b0;
    act = access_on(r_q.s2);
    order_bit = r_q.control[hpp_pkg::CTL_ORDER_BIT];
    r_d.as_prev = r_q.s2.addr_strobe_n;
    r_d.act_prev = act;
    if (r_q.as_prev && !r_q.s2.addr_strobe_n)
    begin
      r_d.cmd = '{r_q.s2.host_read_write, r_q.s2.second_byte_flag,
                  hpp_pkg::hpp_sel_t'({r_q.s2.register_select_hi, r_q.s2.register_select_lo})};
      r_d.cmd_latched = 1'b1;
    end
    c = r_d.cmd;
    if (act && !r_q.act_prev && !r_q.cmd_latched)
    begin
      c = '{r_q.s2.host_read_write, r_q.s2.second_byte_flag,
            hpp_pkg::hpp_sel_t'({r_q.s2.register_select_hi, r_q.s2.register_select_lo})};
      r_d.cmd = c;
    end
    case (r_q.state)
      hpp_pkg::ST_IDLE:
      begin
        if (act && !r_q.act_prev)
        begin
          r_d.state = hpp_pkg::ST_ACTIVE;
          if (c.read)
          begin
            case (c.sel)
              hpp_pkg::SEL_CONTROL: word = r_q.control;
              hpp_pkg::SEL_POINTER: word = r_q.pointer;
              default: word = r_q.latch;
            endcase
            r_d.dout = pick_byte(word, c.second, order_bit);
            r_d.dout_en = 1'b1;
          end
        end
      end
      hpp_pkg::ST_ACTIVE:
      begin
        if (!act)
        begin
          r_d.state = hpp_pkg::ST_IDLE;
          r_d.dout_en = 1'b0;
          r_d.cmd_latched = 1'b0;
          if (!r_q.cmd.read && !r_q.cmd.second)
          begin
            r_d.first_byte = r_q.s2.host_data_bus;
          end
          else if (r_q.cmd.second)
          begin
            word = r_q.cmd.read ? 16'h0000 :
                   (order_bit ? {r_q.s2.host_data_bus, r_q.first_byte}
                        : {r_q.first_byte, r_q.s2.host_data_bus});
            next_ptr = r_q.pointer + 16'h0001;
            case (r_q.cmd.sel)
              hpp_pkg::SEL_CONTROL:
              begin
                if (!r_q.cmd.read)
                begin
                  r_d.control = word & hpp_pkg::CTL_WRITE_MASK;
                end
              end
              hpp_pkg::SEL_POINTER:
              begin
                if (!r_q.cmd.read)
                begin
                  r_d.pointer = word;
                  r_d.mem_addr = word[10:0];
                  r_d.state = hpp_pkg::ST_MEM;
                end
              end
              default:
              begin
                if (r_q.cmd.read && r_q.cmd.sel == hpp_pkg::SEL_DATA_INC)
                begin
                  r_d.pointer = next_ptr;
                  r_d.mem_addr = next_ptr[10:0];
                end
                else if (!r_q.cmd.read)
                begin
                  if (r_q.cmd.sel == hpp_pkg::SEL_DATA_INC)
                  begin
                    r_d.pointer = next_ptr;
                  end
                  r_d.mem_addr = (r_q.cmd.sel == hpp_pkg::SEL_DATA_INC) ?
                                 next_ptr[10:0] : r_q.pointer[10:0];
                  r_d.mem_wdata = word;
                  r_d.latch = word;
                  r_d.mem_we = 1'b1;
                end
                r_d.state = hpp_pkg::ST_MEM;
              end
            endcase
            r_d.busy_cnt = hpp_pkg::MEM_BUSY_CYCLES;
          end
        end
      end
      hpp_pkg::ST_MEM:
      begin
        r_d.busy_cnt = r_q.busy_cnt - 3'h1;
        if (r_q.busy_cnt == 3'h1)
        begin
          // a data write keeps the stored word; ram output is still stale then
          if (r_q.cmd.read || r_q.cmd.sel == hpp_pkg::SEL_POINTER)
          begin
            r_d.latch = mem_rdata;
          end
          r_d.state = hpp_pkg::ST_IDLE;
        end
      end
      default: r_d.state = hpp_pkg::ST_IDLE;
    endcase
    if (i_cpu_set_irq)
    begin
      r_d.control[hpp_pkg::CTL_IRQ_BIT] = 1'b1;
    end
    r_d.dout_en = r_d.dout_en && r_q.s2.emulation_float_n;
    r_d.ready = r_q.s2.port_select_n || (r_d.state != hpp_pkg::ST_MEM);
    r_d.ready_en = r_q.s2.emulation_float_n;
    r_d.irq = !r_d.control[hpp_pkg::CTL_IRQ_BIT];
    r_d.irq_en = r_q.s2.emulation_float_n;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      r_q <= '0;
      r_q.s1.addr_strobe_n <= 1'b1;
      r_q.s1.port_select_n <= 1'b1;
      r_q.s2.addr_strobe_n <= 1'b1;
      r_q.s2.port_select_n <= 1'b1;
      // idle level of the float pin, so outputs are not floated after reset
      r_q.s1.emulation_float_n <= 1'b1;
      r_q.s2.emulation_float_n <= 1'b1;
      r_q.as_prev <= 1'b1;
      r_q.pointer <= hpp_pkg::POINTER_RESET;
      r_q.control <= hpp_pkg::CONTROL_RESET;
      r_q.ready <= 1'b1;
      r_q.ready_en <= 1'b1;
      r_q.irq <= 1'b1;
      r_q.irq_en <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign o_host_data_bus = r_q.dout;
  assign o_host_data_bus_oe = r_q.dout_en;
  assign o_port_ready_out = r_q.ready;
  assign o_port_ready_out_oe = r_q.ready_en;
  assign o_host_irq_out = r_q.irq;
  assign o_host_irq_out_oe = r_q.irq_en;
  assign o_byte_order_bit = r_q.control[hpp_pkg::CTL_ORDER_BIT];

endmodule

// *** test/hpp_host_port_monitor.sv ***
`timescale 1ns/1ps
module hpp_host_port_monitor
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_port_select_n,
  input wire logic i_emulation_float_n,
  input wire logic i_cpu_set_irq,
  input wire logic o_host_data_bus_oe,
  input wire logic o_port_ready_out,
  input wire logic o_port_ready_out_oe,
  input wire logic o_host_irq_out,
  input wire logic o_host_irq_out_oe
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_ready_desel_high: assert property (i_port_select_n [*5] |-> o_port_ready_out)
    else $error("ready low while deselected");
  a_ready_float: assert property (!i_emulation_float_n [*5] |-> !o_port_ready_out_oe)
    else $error("ready driven while floated");
  a_data_float: assert property (!i_emulation_float_n [*5] |-> !o_host_data_bus_oe)
    else $error("data driven while floated");
  a_data_desel_off: assert property (i_port_select_n [*5] |-> !o_host_data_bus_oe)
    else $error("data driven while deselected");
  a_irq_float: assert property (!i_emulation_float_n [*5] |-> !o_host_irq_out_oe)
    else $error("irq driven while floated");
  a_irq_reset_high: assert property (disable iff (1'b0) !i_rst_n |=> o_host_irq_out)
    else $error("irq not high in reset");
  a_irq_set_low: assert property (i_cpu_set_irq |-> ##[1:3] !o_host_irq_out)
    else $error("irq not raised");
  a_ready_returns: assert property ($fell(o_port_ready_out) |-> ##[1:8] o_port_ready_out)
    else $error("ready stuck low");
  cover property ($rose(o_host_data_bus_oe));
  cover property ($fell(o_port_ready_out));
  cover property ($fell(o_host_irq_out));
endmodule
bind hpp_host_port hpp_host_port_monitor i_mon (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_port_select_n(i_port_select_n), .i_emulation_float_n(i_emulation_float_n),
  .i_cpu_set_irq(i_cpu_set_irq), .o_host_data_bus_oe(o_host_data_bus_oe),
  .o_port_ready_out(o_port_ready_out), .o_port_ready_out_oe(o_port_ready_out_oe),
  .o_host_irq_out(o_host_irq_out), .o_host_irq_out_oe(o_host_irq_out_oe));

// *** test/hpp_host_model.sv ***
`timescale 1ns/1ps
module hpp_host_model
(
  input wire logic i_sys_clk,
  input wire logic i_ready,
  output hpp_pkg::hpp_pins_t o_pins,
  output logic o_timeout
);
  initial
  begin
    o_pins = '1;
    o_timeout = 1'b0;
  end
  // m[0]: strobe polarity, m[1]: address strobe in use
  task automatic word(input logic [1:0] s, input logic rd, input logic [15:0] d,
    input logic [1:0] m);
    int n;
    for (int b = 0; b < 2; b++)
    begin
      @(posedge i_sys_clk);
      o_pins.data_strobe_a <= ~m[0];
      o_pins.data_strobe_b <= ~m[0];
      o_pins.second_byte_flag <= b[0];
      {o_pins.register_select_hi, o_pins.register_select_lo} <= s;
      o_pins.host_read_write <= rd;
      o_pins.host_data_bus <= b[0] ? d[7:0] : d[15:8];
      o_pins.addr_strobe_n <= ~m[1];
      o_pins.port_select_n <= 1'b0;
      @(posedge i_sys_clk);
      o_pins.data_strobe_a <= m[0];
      repeat (4) @(posedge i_sys_clk);
      // fields latched by address strobe may now change
      if (m[1])
        {o_pins.register_select_hi, o_pins.register_select_lo, o_pins.second_byte_flag} <= '1;
      repeat (4) @(posedge i_sys_clk);
      o_pins.data_strobe_a <= ~m[0];
      o_pins.addr_strobe_n <= 1'b1;
      @(posedge i_sys_clk);
      o_pins.host_data_bus <= ~o_pins.host_data_bus;
    end
    repeat (6) @(posedge i_sys_clk);
    n = 0;
    while (i_ready !== 1'b1 && n < 50)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n == 50)
      o_timeout <= 1'b1;
    o_pins.port_select_n <= 1'b1;
  endtask
endmodule

// *** test/byte_wide_host_port_pins_tb.sv ***
`timescale 1ns/1ps
module byte_wide_host_port_pins_tb;
  localparam logic [1:0] CT = hpp_pkg::SEL_CONTROL, PT = hpp_pkg::SEL_POINTER;
  localparam logic [1:0] DI = hpp_pkg::SEL_DATA_INC, DK = hpp_pkg::SEL_DATA_KEEP;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic emu_n = 1'b1;
  logic set_irq = 1'b0;
  logic prev_oe = 1'b0;
  logic oe, rdy, rdy_oe, irq, ord, tmo;
  int low_run = 0;
  logic [7:0] dout;
  logic [15:0] v;
  hpp_pkg::hpp_pins_t p;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int checked = 0;
  int seed = 81106;
  initial
  begin
    forever #2 clk = ~clk;
  end
  hpp_host_model i_host (.i_sys_clk(clk), .i_ready(rdy_oe ? rdy : 1'b1), .o_pins(p),
    .o_timeout(tmo));
  hpp_host_port i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr_strobe_n(p.addr_strobe_n),
    .i_port_select_n(p.port_select_n), .i_data_strobe_a(p.data_strobe_a),
    .i_data_strobe_b(p.data_strobe_b), .i_host_read_write(p.host_read_write),
    .i_second_byte_flag(p.second_byte_flag), .i_register_select_hi(p.register_select_hi),
    .i_register_select_lo(p.register_select_lo), .i_emulation_float_n(emu_n),
    .i_host_data_bus(oe ? dout : p.host_data_bus), .i_cpu_set_irq(set_irq),
    .o_host_data_bus(dout), .o_host_data_bus_oe(oe), .o_port_ready_out(rdy),
    .o_port_ready_out_oe(rdy_oe), .o_host_irq_out(irq), .o_host_irq_out_oe(),
    .o_byte_order_bit(ord));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [1:0] s, input logic [15:0] d, input logic [1:0] m);
    exp_q.push_back(d[15:8]);
    exp_q.push_back(d[7:0]);
    i_host.word(s, 1'b1, d, m);
  endtask
  always @(posedge clk)
  begin
    prev_oe <= oe;
    if (oe === 1'b1 && prev_oe === 1'b0)
      chk(dout, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
  end
  // busy spell of ready after each memory transfer, and the timeout exit
  always @(posedge clk)
  begin
    if (rdy_oe === 1'b1 && rdy === 1'b0)
      low_run <= low_run + 1;
    else if (low_run != 0)
    begin
      chk(8'(low_run), 8'(hpp_pkg::MEM_BUSY_CYCLES));
      low_run <= 0;
    end
    if (tmo === 1'b1)
      end_of_test();
  end
  task automatic end_of_test;
    if (tmo !== 1'b0 || exp_q.size() != 0)
    begin
      fail_count++;
      $display("MISMATCH %0t hang or missing read data", $time);
    end
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int m = 0; m < 4; m++)
    begin
      v = 16'($random(seed));
      i_host.word(PT, 1'b0, v, m[1:0]);
      rd(PT, v, m[1:0]);
    end
    i_host.word(CT, 1'b0, 16'h0101, 2'h0);
    chk({7'h00, ord}, 8'h01);
    i_host.word(PT, 1'b0, 16'h4567, 2'h1);
    i_host.word(CT, 1'b0, 16'h0000, 2'h0);
    rd(PT, 16'h6745, 2'h0);
    v = 16'($random(seed));
    i_host.word(PT, 1'b0, 16'h07FF, 2'h2);
    i_host.word(DI, 1'b0, v, 2'h0);
    rd(DK, v, 2'h1);
    rd(PT, 16'h0800, 2'h0);
    i_host.word(PT, 1'b0, 16'h0800, 2'h0);
    rd(DK, v, 2'h3);
    rd(PT, 16'h0800, 2'h0);
    rd(DI, v, 2'h0);
    rd(PT, 16'h0801, 2'h0);
    set_irq <= 1'b1;
    @(posedge clk);
    set_irq <= 1'b0;
    repeat (4) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    i_host.word(CT, 1'b0, 16'h0000, 2'h0);
    chk({7'h00, irq}, 8'h01);
    emu_n <= 1'b0;
    i_host.word(PT, 1'b1, 16'h0000, 2'h0);
    emu_n <= 1'b1;
    repeat (8) @(posedge clk);
    end_of_test();
  end
endmodule
